//--- design/otpsb_pkg.sv
package otpsb_pkg;

  // Timing at the 100 MHz system clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INIT_TIME_NS  = 15000;
  localparam int unsigned INIT_CYC      =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // OTP geometry
  localparam int unsigned OTP_SECTORS   = 4;
  localparam int unsigned OTP_ROWS      = 512;
  localparam int unsigned OTP_WORDS     = OTP_SECTORS * OTP_ROWS;
  localparam int unsigned OTP_AW        = 11;

  // Register byte offsets
  localparam logic [7:0] OFS_OTP_ADDR   = 8'h00;
  localparam logic [7:0] OFS_OTP_DATA   = 8'h04;
  localparam logic [7:0] OFS_OTP_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_SECURITY   = 8'h10;
  localparam logic [7:0] OFS_OTP_RDATA  = 8'h14;

  // OTP control port fields
  localparam int unsigned CTRL_PROG     = 0;
  localparam int unsigned CTRL_READ     = 1;
  localparam int unsigned CTRL_JTAG     = 2;
  localparam int unsigned CTRL_SECWORD  = 3;

  // Status fields
  localparam int unsigned STAT_LOADED   = 0;
  localparam int unsigned STAT_BOOTED   = 1;
  localparam int unsigned STAT_REJECT   = 2;
  localparam int unsigned STAT_SRC_LSB  = 4;
  localparam int unsigned STAT_SPD_LSB  = 6;

  // Security register fields
  localparam int unsigned SEC_NO_JTAG   = 0;
  localparam int unsigned SEC_NO_LINK   = 1;
  localparam int unsigned SEC_BOOT_OTP  = 5;
  localparam int unsigned SEC_REDUND    = 7;
  localparam int unsigned SEC_LOCK_LSB  = 8;
  localparam int unsigned SEC_MASTER    = 12;
  localparam int unsigned SEC_NO_JOTP   = 13;
  localparam int unsigned SEC_NO_DBG    = 14;
  localparam int unsigned SEC_GP_LSB    = 15;
  localparam int unsigned SEC_GP_MSB    = 21;
  localparam int unsigned SEC_UID_LSB   = 22;
  localparam int unsigned SEC_UID_MSB   = 31;
  localparam logic [31:0] SEC_DEF_MASK  = 32'hFFFF_FFA3;
  localparam logic [31:0] SEC_GP_MASK   = 32'h003F_8000;
  localparam logic [31:0] SEC_RESET     = 32'h0000_0000;

  // Boot sources and channel boot constants
  localparam logic [1:0]  SRC_CHAN      = 2'h1;
  localparam logic [31:0] NULL_CHAN_END = 32'h0000_FF02;

  typedef enum logic [3:0] {
    ST_INIT, ST_LOAD, ST_COPY_RD, ST_COPY_WR, ST_SELECT,
    ST_CH_ACK, ST_CH_IMG, ST_CH_END, ST_JUMP, ST_RUN
  } otpsb_state_t;

  typedef struct packed {
    logic        ctrl;
    logic [31:0] data;
  } otpsb_chan_word_t;

  typedef struct packed {
    logic [10:0] addr;
    logic [31:0] data;
  } otpsb_sram_wr_t;

endpackage

//--- design/otpsb_loader.sv
`timescale 1ns/1ps
// How it works
// R1: GPIO pins high impedance while reset low
// R2: After init delay enable pulls, latch speed straps (code latches straps on the first clock after reset release)
// R3: Boot source taken from upper two straps
// R4: Security bit 5 forces boot from OTP 0
// R5: Host keeps straps steady around reset release
// R6: Channel boot: take ack channel word first
// R7: Image, end token, reply end, free, jump
// R8: Security word loaded before any feature acts
// R9: OTP is four sectors of 512 words
// R10: Copy OTP to SRAM before any boot
// R11: Program OTP via address, data, control ports
// R12: Bit 0 blocks JTAG access to tile
// R13: Bit 1 blocks link access to processor
// R14: Bit 7 enables redundant OTP rows
// R15: Bits 8 to 11 lock sector programming
// R16: Bit 12 blocks all OTP programming
// R17: Bit 13 blocks JTAG reads and writes of OTP
// R18: Bit 14 disables debug sync pin
// R19: Bits 15 to 21 software general purpose
// R20: Bits 22 to 31 hold user ID extension
// R21: User code returns bits 22 to 31
// R22: Bits 2, 3, 4, 6 reserved, read zero
module otpsb_loader (
  input  wire logic                      clk_sys_i,
  input  wire logic                      nrst_i,
  input  wire logic [7:0]                avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  output logic      [31:0]               avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire logic                      boot_speed_strap_a_i,
  input  wire logic                      boot_speed_strap_b_i,
  input  wire logic [1:0]                boot_src_strap_i,
  output logic                           gpio_hiz_o,
  output logic                           gpio_pull_en_o,
  output logic      [1:0]                boot_speed_o,
  output logic      [1:0]                boot_src_o,
  output logic                           boot_from_otp_o,
  output logic                           boot_jump_o,
  output logic                           sram_wr_valid_o,
  output otpsb_pkg::otpsb_sram_wr_t      sram_wr_o,
  input  wire logic                      sram_wr_ready_i,
  input  wire logic                      chan_rx_valid_i,
  input  wire otpsb_pkg::otpsb_chan_word_t chan_rx_i,
  output logic                           chan_rx_ready_o,
  output logic                           img_valid_o,
  output logic      [31:0]               img_data_o,
  input  wire logic                      img_ready_i,
  output logic                           chan_end0_alloc_o,
  output logic                           chan_tx_end_valid_o,
  output logic      [31:0]               chan_tx_dest_o,
  input  wire logic                      chan_tx_ready_i,
  output logic                           jtag_access_en_o,
  output logic                           link_access_en_o,
  output logic                           jtag_otp_en_o,
  output logic                           debug_pin_en_o,
  output logic                           redundant_rows_en_o,
  output logic      [9:0]                usercode_id_o
);

  otpsb_pkg::otpsb_state_t state_q;
  // Blank fuses read as zero; they keep their state across nrst_i
  logic [31:0]           otp_mem [otpsb_pkg::OTP_WORDS]
                           = '{default: 32'h0000_0000};
  logic [31:0]           otp_sec_word = 32'h0000_0000;
  logic [31:0]           sec_q;
  logic                  sec_valid_q;
  logic [10:0]           init_cnt_q;
  logic [10:0]           copy_idx_q;
  logic [15:0]           otp_addr_q;
  logic [31:0]           otp_data_q;
  logic [31:0]           otp_rdata_q;
  logic                  reject_q;
  logic                  booted_q;
  logic                  resp_q;
  logic [31:0]           rd_q;
  logic [31:0]           ack_dest_q;
  logic                  req;
  logic                  wr_acc;
  logic                  prog_go;
  logic                  read_go;
  logic                  prog_bad;
  logic                  read_bad;
  logic [10:0]           prog_row;
  logic [1:0]            prog_sector;
  logic                  rx_take;

  ////////////////////////////////////////////////////////////////////////////
  // OTP programming and read-out

  assign prog_row    = otp_addr_q[10:0];
  assign prog_sector = prog_row[10:9]; // R9
  assign prog_go     = wr_acc && avs_address_i == otpsb_pkg::OFS_OTP_CTRL
                       && avs_writedata_i[otpsb_pkg::CTRL_PROG]; // R11
  assign read_go     = wr_acc && avs_address_i == otpsb_pkg::OFS_OTP_CTRL
                       && avs_writedata_i[otpsb_pkg::CTRL_READ];

  // Refuse programming before the lock bits are known
  always_comb
  begin
    prog_bad = !sec_valid_q
      || sec_q[otpsb_pkg::SEC_MASTER] // R16
      || (avs_writedata_i[otpsb_pkg::CTRL_JTAG]
          && sec_q[otpsb_pkg::SEC_NO_JOTP]) // R17
      || (otp_addr_q[15:11] != 5'h00
          && !avs_writedata_i[otpsb_pkg::CTRL_SECWORD])
      || (!avs_writedata_i[otpsb_pkg::CTRL_SECWORD]
          && sec_q[otpsb_pkg::SEC_LOCK_LSB + 32'(prog_sector)]); // R15
    read_bad = !sec_valid_q || otp_addr_q[15:11] != 5'h00
      || (avs_writedata_i[otpsb_pkg::CTRL_JTAG]
          && sec_q[otpsb_pkg::SEC_NO_JOTP]); // R17
  end

  // Fuses only ever go from 0 to 1, hence the OR
  always_ff @(posedge clk_sys_i)
  begin
    if (prog_go && !prog_bad)
    begin
      if (avs_writedata_i[otpsb_pkg::CTRL_SECWORD])
        otp_sec_word <= otp_sec_word | otp_data_q;
      else
        otp_mem[prog_row] <= otp_mem[prog_row] | otp_data_q; // R11
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      otp_rdata_q <= 32'h0000_0000;
    else if (read_go && !read_bad)
      otp_rdata_q <= otp_mem[prog_row];
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reject_q <= 1'b0;
    else if ((prog_go && prog_bad) || (read_go && read_bad))
      reject_q <= 1'b1; // R15
    else if (wr_acc && avs_address_i == otpsb_pkg::OFS_STATUS
             && avs_writedata_i[otpsb_pkg::STAT_REJECT])
      reject_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state on every access

  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !resp_q;
  assign wr_acc            = avs_write_i && resp_q;
  assign avs_readdata_o    = rd_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      resp_q <= 1'b0;
    else
      resp_q <= req && !resp_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_q <= 32'h0000_0000;
    else if (avs_read_i && !resp_q)
    begin
      case (avs_address_i)
        otpsb_pkg::OFS_OTP_ADDR:  rd_q <= {16'h0000, otp_addr_q};
        otpsb_pkg::OFS_OTP_DATA:  rd_q <= otp_data_q;
        otpsb_pkg::OFS_OTP_RDATA: rd_q <= otp_rdata_q;
        otpsb_pkg::OFS_SECURITY:  rd_q <= sec_q;
        otpsb_pkg::OFS_STATUS:
          rd_q <= {24'h00_0000, boot_speed_o, boot_src_o, 1'b0,
                   reject_q, booted_q, sec_valid_q};
        default:                  rd_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      otp_addr_q <= 16'h0000;
      otp_data_q <= 32'h0000_0000;
    end
    else if (wr_acc && avs_address_i == otpsb_pkg::OFS_OTP_ADDR)
      otp_addr_q <= avs_writedata_i[15:0]; // R11
    else if (wr_acc && avs_address_i == otpsb_pkg::OFS_OTP_DATA)
      otp_data_q <= avs_writedata_i; // R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security register and the features it gates

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sec_q       <= otpsb_pkg::SEC_RESET;
      sec_valid_q <= 1'b0;
    end
    else if (state_q == otpsb_pkg::ST_LOAD)
    begin
      sec_q       <= otp_sec_word & otpsb_pkg::SEC_DEF_MASK; // R8 R22
      sec_valid_q <= 1'b1;
    end
    else if (wr_acc && avs_address_i == otpsb_pkg::OFS_SECURITY)
      sec_q <= (sec_q & ~otpsb_pkg::SEC_GP_MASK)
               | (avs_writedata_i & otpsb_pkg::SEC_GP_MASK); // R19
  end

  // Nothing is opened up until the word is loaded
  assign jtag_access_en_o    = sec_valid_q
                               && !sec_q[otpsb_pkg::SEC_NO_JTAG]; // R8 R12
  assign link_access_en_o    = sec_valid_q
                               && !sec_q[otpsb_pkg::SEC_NO_LINK]; // R13
  assign jtag_otp_en_o       = jtag_access_en_o
                               && !sec_q[otpsb_pkg::SEC_NO_JOTP]; // R17
  assign debug_pin_en_o      = sec_valid_q
                               && !sec_q[otpsb_pkg::SEC_NO_DBG]; // R18
  assign redundant_rows_en_o = sec_valid_q
                               && sec_q[otpsb_pkg::SEC_REDUND]; // R14
  assign usercode_id_o       = sec_q[otpsb_pkg::SEC_UID_MSB:
                                     otpsb_pkg::SEC_UID_LSB]; // R20 R21

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer

  assign rx_take = chan_rx_valid_i && chan_rx_ready_o;

  always_comb
  begin
    case (state_q)
      otpsb_pkg::ST_CH_ACK: chan_rx_ready_o = 1'b1; // R6
      otpsb_pkg::ST_CH_IMG: chan_rx_ready_o = !img_valid_o;
      default:              chan_rx_ready_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q    <= otpsb_pkg::ST_INIT;
      init_cnt_q <= 11'h000;
      copy_idx_q <= 11'h000;
    end
    else
    begin
      case (state_q)
        otpsb_pkg::ST_INIT:
        begin
          init_cnt_q <= init_cnt_q + 11'h001;
          if (init_cnt_q == 11'(otpsb_pkg::INIT_CYC - 1))
            state_q <= otpsb_pkg::ST_LOAD; // R2
        end
        otpsb_pkg::ST_LOAD:
          state_q <= otpsb_pkg::ST_COPY_RD; // R8
        otpsb_pkg::ST_COPY_RD:
          state_q <= otpsb_pkg::ST_COPY_WR;
        otpsb_pkg::ST_COPY_WR:
        begin
          if (sram_wr_ready_i)
          begin
            copy_idx_q <= copy_idx_q + 11'h001;
            if (copy_idx_q == 11'(otpsb_pkg::OTP_WORDS - 1))
              state_q <= otpsb_pkg::ST_SELECT; // R10
            else
              state_q <= otpsb_pkg::ST_COPY_RD;
          end
        end
        otpsb_pkg::ST_SELECT:
        begin
          if (!sec_q[otpsb_pkg::SEC_BOOT_OTP]
              && boot_src_o == otpsb_pkg::SRC_CHAN)
            state_q <= otpsb_pkg::ST_CH_ACK; // R3 R4
          else
            state_q <= otpsb_pkg::ST_JUMP;
        end
        otpsb_pkg::ST_CH_ACK:
          if (rx_take)
            state_q <= otpsb_pkg::ST_CH_IMG; // R6
        otpsb_pkg::ST_CH_IMG:
        begin
          if (rx_take && chan_rx_i.ctrl)
          begin
            if (ack_dest_q == otpsb_pkg::NULL_CHAN_END)
              state_q <= otpsb_pkg::ST_JUMP; // R6
            else
              state_q <= otpsb_pkg::ST_CH_END; // R7
          end
        end
        otpsb_pkg::ST_CH_END:
          if (chan_tx_ready_i)
            state_q <= otpsb_pkg::ST_JUMP; // R7
        otpsb_pkg::ST_JUMP:
          state_q <= otpsb_pkg::ST_RUN;
        otpsb_pkg::ST_RUN:
          state_q <= otpsb_pkg::ST_RUN;
        default:
          state_q <= otpsb_pkg::ST_INIT;
      endcase
    end
  end

  // Straps are caught once, after release; the host keeps them still
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      boot_speed_o <= 2'h0;
      boot_src_o   <= 2'h0;
    end
    else if (state_q == otpsb_pkg::ST_INIT && init_cnt_q == 11'h000)
    begin
      boot_speed_o <= {boot_speed_strap_b_i, boot_speed_strap_a_i}; // R2 R5
      boot_src_o   <= boot_src_strap_i; // R3
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gpio_hiz_o     <= 1'b1; // R1
      gpio_pull_en_o <= 1'b0;
    end
    else if (state_q == otpsb_pkg::ST_LOAD)
    begin
      gpio_hiz_o     <= 1'b0;
      gpio_pull_en_o <= 1'b1; // R2
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sram_wr_valid_o <= 1'b0;
      sram_wr_o       <= '0;
    end
    else if (state_q == otpsb_pkg::ST_COPY_RD)
    begin
      sram_wr_valid_o <= 1'b1; // R10
      sram_wr_o.addr  <= copy_idx_q;
      sram_wr_o.data  <= otp_mem[copy_idx_q];
    end
    else if (sram_wr_ready_i)
      sram_wr_valid_o <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      img_valid_o <= 1'b0;
      img_data_o  <= 32'h0000_0000;
      ack_dest_q  <= 32'h0000_0000;
    end
    else
    begin
      if (state_q == otpsb_pkg::ST_CH_ACK && rx_take)
        ack_dest_q <= chan_rx_i.data; // R6
      if (state_q == otpsb_pkg::ST_CH_IMG && rx_take && !chan_rx_i.ctrl)
      begin
        img_valid_o <= 1'b1; // R7
        img_data_o  <= chan_rx_i.data;
      end
      else if (img_ready_i)
        img_valid_o <= 1'b0;
    end
  end

  assign chan_tx_end_valid_o = state_q == otpsb_pkg::ST_CH_END; // R7
  assign chan_tx_dest_o      = ack_dest_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      chan_end0_alloc_o <= 1'b0;
      boot_jump_o       <= 1'b0;
      boot_from_otp_o   <= 1'b0;
      booted_q          <= 1'b0;
    end
    else
    begin
      if (state_q == otpsb_pkg::ST_SELECT)
      begin
        chan_end0_alloc_o <= !sec_q[otpsb_pkg::SEC_BOOT_OTP]
                             && boot_src_o == otpsb_pkg::SRC_CHAN; // R6
        boot_from_otp_o   <= sec_q[otpsb_pkg::SEC_BOOT_OTP]; // R4
      end
      else if (state_q == otpsb_pkg::ST_JUMP)
        chan_end0_alloc_o <= 1'b0; // R7
      boot_jump_o <= state_q == otpsb_pkg::ST_JUMP; // R7
      if (state_q == otpsb_pkg::ST_JUMP)
        booted_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_hiz_in_reset;
    @(posedge clk_sys_i) !nrst_i |-> gpio_hiz_o;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset) // R1
    else $error("gpio not high impedance in reset");

  property p_pull_after_init;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(nrst_i) ##0 !gpio_pull_en_o |-> !gpio_pull_en_o [*8];
  endproperty
  a_pull_after_init: assert property (p_pull_after_init) // R2
    else $error("pulls enabled too early");

  property p_sec_before_use;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (jtag_access_en_o || link_access_en_o || debug_pin_en_o)
      |-> sec_valid_q && state_q != otpsb_pkg::ST_INIT;
  endproperty
  a_sec_before_use: assert property (p_sec_before_use) // R8
    else $error("access open before security load");

  property p_jtag_block;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    sec_q[otpsb_pkg::SEC_NO_JTAG] |-> !jtag_access_en_o && !jtag_otp_en_o;
  endproperty
  a_jtag_block: assert property (p_jtag_block) // R12
    else $error("jtag open with bit 0 set");

  property p_sector_lock;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    prog_go && !avs_writedata_i[otpsb_pkg::CTRL_SECWORD]
      && sec_q[otpsb_pkg::SEC_LOCK_LSB + 32'(prog_sector)]
      |=> reject_q && $stable(otp_mem[$past(prog_row)]);
  endproperty
  a_sector_lock: assert property (p_sector_lock) // R15
    else $error("locked sector programmed");

  property p_master_lock;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    prog_go && sec_q[otpsb_pkg::SEC_MASTER]
      |=> reject_q && $stable(otp_sec_word);
  endproperty
  a_master_lock: assert property (p_master_lock) // R16
    else $error("programming under master lock");

  property p_secure_boot;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    boot_jump_o && sec_q[otpsb_pkg::SEC_BOOT_OTP]
      |-> boot_from_otp_o && !chan_end0_alloc_o;
  endproperty
  a_secure_boot: assert property (p_secure_boot) // R4
    else $error("secure boot not from otp");

  property p_end_reply;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == otpsb_pkg::ST_CH_IMG && rx_take && chan_rx_i.ctrl
      && ack_dest_q != otpsb_pkg::NULL_CHAN_END
      |=> chan_tx_end_valid_o && chan_end0_alloc_o;
  endproperty
  a_end_reply: assert property (p_end_reply) // R7
    else $error("end token not returned");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    sec_q[6] == 1'b0 && sec_q[4:2] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R22
    else $error("reserved security bits set");

  property p_copy_first;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(boot_jump_o) |-> sec_valid_q && copy_idx_q == 11'h000
      && $past(booted_q) == 1'b0;
  endproperty
  a_copy_first: assert property (p_copy_first) // R10
    else $error("jump before otp copy");

  c_chan_boot: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    boot_jump_o && chan_end0_alloc_o);
  c_secure_boot: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    boot_jump_o && boot_from_otp_o);
  c_reject: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(reject_q));

endmodule

//--- verification/otpsb_host_model.sv
`timescale 1ns/1ps
// Boot host: ack channel, three image words, END; stalls SRAM and image ready every other cycle
module otpsb_host_model (
  input  wire logic                          clk_sys_i,
  input  wire logic                          nrst_i,
  input  wire logic                          chan_rx_ready_i,
  output logic                               chan_rx_valid_o,
  output otpsb_pkg::otpsb_chan_word_t        chan_rx_o,
  output logic                               sram_wr_ready_o,
  output logic                               img_ready_o,
  input  wire logic                          chan_tx_end_valid_i,
  output logic                               chan_tx_ready_o
);
  logic [2:0] idx_q;
  logic       tog_q;
  logic [1:0] txw_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i) idx_q <= 3'h0;
    else if (chan_rx_valid_o && chan_rx_ready_i) idx_q <= idx_q + 3'h1;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i) tog_q <= 1'b0;
    else tog_q <= !tog_q;
  end
  // Slow acceptance of the END token so the device must hold it
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i) txw_q <= 2'h0;
    else if (!chan_tx_end_valid_i) txw_q <= 2'h0;
    else if (txw_q != 2'h3) txw_q <= txw_q + 2'h1;
  end
  always_comb
  begin
    chan_rx_valid_o = (idx_q < 3'h5);
    chan_rx_o.ctrl = (idx_q == 3'h4);
    chan_rx_o.data = 32'hC0DE_0000 + 32'(idx_q) - 32'h1;
    if (idx_q == 3'h0) chan_rx_o.data = 32'h0000_0123;
    if (idx_q == 3'h4) chan_rx_o.data = 32'h0000_0000;
    // Released line shows the inverse of the last word
    if (!chan_rx_valid_o) chan_rx_o.data = 32'hFFFF_FFFF;
  end
  assign sram_wr_ready_o = tog_q;
  assign img_ready_o = tog_q;
  assign chan_tx_ready_o = (txw_q == 2'h3);
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  // Starts high so that the first reset makes a real falling edge
  logic nrst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic boot_speed_strap_a_i = 1'b1;
  logic boot_speed_strap_b_i = 1'b0;
  logic [1:0] boot_src_strap_i = 2'h1;
  logic [31:0] avs_readdata_o, img_data_o, chan_tx_dest_o, rd;
  logic [1:0] boot_speed_o, boot_src_o;
  logic [9:0] usercode_id_o;
  logic avs_waitrequest_o, gpio_hiz_o, gpio_pull_en_o, boot_from_otp_o;
  logic boot_jump_o, sram_wr_valid_o, sram_wr_ready_i, chan_rx_valid_i;
  logic chan_rx_ready_o, img_valid_o, img_ready_i, chan_end0_alloc_o;
  logic chan_tx_end_valid_o, chan_tx_ready_i, jtag_access_en_o;
  logic link_access_en_o, jtag_otp_en_o, debug_pin_en_o, redundant_rows_en_o;
  otpsb_pkg::otpsb_sram_wr_t   sram_wr_o;
  otpsb_pkg::otpsb_chan_word_t chan_rx_i;
  int failures = 0;
  int n_compared = 0;
  int img_n = 0;
  logic [31:0] dest_seen = 32'h0;
  logic [31:0] copy_exp = 32'h0;
  always #5 clk_sys_i = ~clk_sys_i;
  otpsb_loader otpsb_loader_inst (.clk_sys_i, .nrst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .boot_speed_strap_a_i, .boot_speed_strap_b_i,
    .boot_src_strap_i, .gpio_hiz_o, .gpio_pull_en_o, .boot_speed_o,
    .boot_src_o, .boot_from_otp_o, .boot_jump_o, .sram_wr_valid_o,
    .sram_wr_o, .sram_wr_ready_i, .chan_rx_valid_i, .chan_rx_i,
    .chan_rx_ready_o, .img_valid_o, .img_data_o, .img_ready_i,
    .chan_end0_alloc_o, .chan_tx_end_valid_o, .chan_tx_dest_o,
    .chan_tx_ready_i, .jtag_access_en_o, .link_access_en_o, .jtag_otp_en_o,
    .debug_pin_en_o, .redundant_rows_en_o, .usercode_id_o);
  otpsb_host_model otpsb_host_model_inst (.clk_sys_i, .nrst_i,
    .chan_rx_ready_i(chan_rx_ready_o), .chan_rx_valid_o(chan_rx_valid_i),
    .chan_rx_o(chan_rx_i), .sram_wr_ready_o(sram_wr_ready_i),
    .img_ready_o(img_ready_i), .chan_tx_end_valid_i(chan_tx_end_valid_o),
    .chan_tx_ready_o(chan_tx_ready_i));
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) failures++;
    if (n >= 40) results();
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task rdchk(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task prog(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    bus(1'b1, otpsb_pkg::OFS_OTP_ADDR, a);
    bus(1'b1, otpsb_pkg::OFS_OTP_DATA, d);
    bus(1'b1, otpsb_pkg::OFS_OTP_CTRL, c);
  endtask
  task boot_up;
    int n;
    nrst_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    chk("gpio_hiz", 1'b1, gpio_hiz_o);
    nrst_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (boot_jump_o !== 1'b1 && n < 20000);
    if (n >= 20000) failures++;
    if (n >= 20000) results();
    @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i)
  begin
    if (img_valid_o && img_ready_i)
    begin
      chk("img_data", 32'hC0DE_0000 + img_n, img_data_o);
      img_n++;
    end
    if (chan_tx_end_valid_o && chan_tx_ready_i)
    begin
      dest_seen = chan_tx_dest_o;
      chk("alloc", 1'b1, chan_end0_alloc_o);
    end
    if (sram_wr_valid_o && sram_wr_ready_i && sram_wr_o.addr == 11'h201)
      chk("sram_copy", copy_exp, sram_wr_o.data);
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    boot_up();
    chk("pull_en", 1'b1, gpio_pull_en_o);
    chk("speed", 2'h1, boot_speed_o);
    chk("src", 2'h1, boot_src_o);
    chk("from_otp", 1'b0, boot_from_otp_o);
    chk("img_count", 3, img_n);
    chk("ack_dest", 32'h0000_0123, dest_seen);
    chk("jtag_en", 1'b1, jtag_access_en_o);
    chk("alloc_free", 1'b0, chan_end0_alloc_o);
    rdchk(otpsb_pkg::OFS_STATUS, "status", 32'h53);
    rdchk(otpsb_pkg::OFS_SECURITY, "security", 32'h0);
    bus(1'b1, otpsb_pkg::OFS_SECURITY, 32'hFFFF_FFFF);
    rdchk(otpsb_pkg::OFS_SECURITY, "sec_gp", 32'h003F_8000);
    rdchk(8'h40, "unmapped", 32'h0);
    prog(32'h0, 32'hA940_62FF, 32'h9);
    prog(32'h201, 32'h1234_5678, 32'h1);
    copy_exp = 32'h1234_5678;
    bus(1'b1, otpsb_pkg::OFS_OTP_CTRL, 32'h2);
    rdchk(otpsb_pkg::OFS_OTP_RDATA, "otp_rdata", 32'h1234_5678);
    prog(32'h800, 32'h1, 32'h1);
    rdchk(otpsb_pkg::OFS_STATUS, "range_reject", 32'h57);
    // Secure word only acts after the next reload
    boot_up();
    chk("img_count2", 3, img_n);
    chk("from_otp2", 1'b1, boot_from_otp_o);
    chk("jtag_en2", 1'b0, jtag_access_en_o);
    chk("link_en2", 1'b0, link_access_en_o);
    chk("redund2", 1'b1, redundant_rows_en_o);
    chk("jtag_otp2", 1'b0, jtag_otp_en_o);
    chk("debug2", 1'b0, debug_pin_en_o);
    chk("usercode", 10'h2A5, usercode_id_o);
    rdchk(otpsb_pkg::OFS_SECURITY, "security2", 32'hA940_62A3);
    prog(32'h200, 32'h1, 32'h1);
    rdchk(otpsb_pkg::OFS_STATUS, "lock_reject", 32'h57);
    bus(1'b1, otpsb_pkg::OFS_STATUS, 32'h4);
    prog(32'h001, 32'h1, 32'h1);
    rdchk(otpsb_pkg::OFS_STATUS, "open_sector", 32'h53);
    prog(32'h001, 32'h2, 32'h5);
    rdchk(otpsb_pkg::OFS_STATUS, "jtag_reject", 32'h57);
    prog(32'h0, 32'h0000_1000, 32'h9);
    boot_up();
    rdchk(otpsb_pkg::OFS_SECURITY, "security3", 32'hA940_72A3);
    prog(32'h002, 32'h1, 32'h1);
    rdchk(otpsb_pkg::OFS_STATUS, "master_reject", 32'h57);
    results();
  end
endmodule
